// *** inc/rcs_pkg.sv ***
// reset and clock select package: register map, field positions, reset values, carriers
// assumes a 32-bit classic wishbone slave on the system clock; one register per aligned word
package rcs_pkg;
    // register indices (byte address is four times the index)
    localparam logic [3:0] RCS_IDX_PM0 = 4'h4;
    localparam logic [3:0] RCS_IDX_PM1 = 4'h5;
    localparam logic [3:0] RCS_IDX_CM0 = 4'h6;
    localparam logic [3:0] RCS_IDX_STAT = 4'h8;
    localparam logic [3:0] RCS_IDX_PROT = 4'hA;
    localparam logic [3:0] RCS_IDX_CTRL = 4'hB;
    // reset values
    localparam logic [7:0] RCS_PM1_RST = 8'h08;
    localparam logic [7:0] RCS_CM0_RST = 8'h48;
    // processor mode 1 fields
    localparam int RCS_PM1_DATA_BLOCK = 0;
    localparam int RCS_PM1_WDT_ACTION = 2;
    localparam int RCS_PM1_AREA_EXP = 3;
    localparam int RCS_PM1_ACC_WAIT = 7;
    localparam logic [7:0] RCS_PM1_WMASK = 8'h89; // writable plain bits
    // processor mode 0 field
    localparam int RCS_PM0_SOFT_RST = 3;
    // clock control 0 fields
    localparam int RCS_CM0_CLKOUT_LO = 0;
    localparam int RCS_CM0_WAIT_STOP = 2;
    localparam int RCS_CM0_SUB_DRIVE = 3;
    localparam int RCS_CM0_SUB_PIN_EN = 4;
    localparam int RCS_CM0_MAIN_STOP = 5;
    localparam int RCS_CM0_DIV8 = 6;
    localparam int RCS_CM0_SUB_SEL = 7;
    // control register fields (on-chip select, stop action, main drive)
    localparam int RCS_CTRL_ONCHIP = 0;
    localparam int RCS_CTRL_STOP_ACT = 1;
    localparam int RCS_CTRL_MAIN_DRV = 2;
    localparam logic [7:0] RCS_CTRL_RST = 8'h04;
    // status: sticky reset cause bits 3:0 (pin, soft, wdt, osc stop)
    localparam int RCS_CAUSE_PIN = 0;
    localparam int RCS_CAUSE_SOFT = 1;
    localparam int RCS_CAUSE_WDT = 2;
    localparam int RCS_CAUSE_OSC = 3;
    // memory limits when area expansion is zero
    localparam logic [19:0] RCS_RAM_LO = 20'h00400;
    localparam logic [19:0] RCS_RAM_HI = 20'h03FFF;
    localparam logic [19:0] RCS_ROM_LO = 20'hD0000;
    // reset stretch in system clocks after all causes clear
    localparam logic [3:0] RCS_STRETCH = 4'h4;
    // clock divider widths
    localparam int RCS_DIV_W = 5;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [3:0] idx;
        logic [31:0] dat;
    } rcs_wb_req_t;

    // first member lands on bit 7, so fields are listed from the top bit down
    typedef struct packed {
        logic sub_sel;
        logic div8;
        logic main_stop;
        logic sub_pin_en;
        logic sub_drive;
        logic wait_stop;
        logic [1:0] clkout_sel;
    } rcs_cm0_t;
endpackage : rcs_pkg

// *** rtl/rcs_top.sv ***
// reset combiner, processor mode 1 and clock control 0 with wishbone register access
// assumes synchronous clock sources fc_in and the watchdog underflow pulse on CLK_IN;
// external pins (reset, oscillator stop) are asynchronous and synchronised here
module rcs_top
    import rcs_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [31:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire logic RESET_N_IN,
    input wire logic OSC_STOP_IN,
    input wire logic WDT_UNDERFLOW_IN,
    input wire logic FLASH_REWRITE_IN,
    input wire logic STOP_ENTRY_IN,
    input wire logic STOP_FROM_FAST_IN,
    input wire logic WAIT_MODE_IN,
    input wire logic FC_IN,
    input wire logic MEM_REQ_IN,
    input wire logic [19:0] MEM_ADDR_IN,
    input wire logic MEM_IS_ROM_IN,
    output logic MEM_READY_OUT,
    output logic MEM_ALLOWED_OUT,
    output logic SYS_RESET_OUT,
    output logic PORTS_INPUT_OUT,
    output logic OSC_RESET_OUT,
    output logic CPU_HALT_OUT,
    output logic CLKOUT_OUT,
    output logic CLKOUT_OE_OUT,
    output logic PERIPH_CLK_EN_OUT,
    output logic SUB_DIV32_EN_OUT,
    output logic WDT_IRQ_OUT,
    output logic OSC_IRQ_OUT,
    output logic [7:0] PM1_OUT,
    output logic [7:0] CM0_OUT
);

    // three-stage synchronisers for the reset pin and stop detector
    logic [2:0] rstn_sync_r, rstn_sync_nxt;
    logic [2:0] osc_sync_r, osc_sync_nxt;
    logic pin_low_r, pin_low_nxt;
    logic osc_stop_r, osc_stop_nxt;

    // registers
    logic [7:0] pm1_r, pm1_nxt;
    rcs_cm0_t cm0_r, cm0_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic prot_r, prot_nxt;
    logic [3:0] cause_r, cause_nxt;
    logic soft_req_r, soft_req_nxt;
    logic halt_r, halt_nxt;
    logic [3:0] stretch_r, stretch_nxt;
    logic sys_rst_r, sys_rst_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic [RCS_DIV_W-1:0] div_r, div_nxt;
    logic clkout_r, clkout_nxt;
    logic mem_wait_r, mem_wait_nxt;

    // decode terms, all combinational from registered state and module inputs
    logic wb_hit; // new request, not the cycle that already holds ack
    logic wb_wr; // write with the low byte lane enabled
    logic soft_wr; // software reset request written
    logic wdt_rst; // watchdog underflow with reset action selected
    logic osc_rst; // oscillator stop with reset action selected
    logic any_cause; // union of every reset source
    logic ram_ok; // address inside the narrow ram window
    logic rom_ok; // address inside the narrow rom window

    function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo, input logic [19:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // pin synchronisers: a change counts once stages two and three agree
    always_comb begin
        rstn_sync_nxt = {rstn_sync_r[1:0], RESET_N_IN};
        osc_sync_nxt = {osc_sync_r[1:0], OSC_STOP_IN};
        pin_low_nxt = pin_low_r;
        osc_stop_nxt = osc_stop_r;
        if (rstn_sync_r[2] == rstn_sync_r[1]) begin
            pin_low_nxt = ~rstn_sync_r[2];
        end
        if (osc_sync_r[2] == osc_sync_r[1]) begin
            osc_stop_nxt = osc_sync_r[2];
        end
    end

    // request decode; ack falls the cycle after it is given
    always_comb begin
        wb_hit = WB_CYC_IN && WB_STB_IN && !ack_r;
        wb_wr = wb_hit && WB_WE_IN && WB_SEL_IN[0];
        soft_wr = wb_wr && (WB_ADR_IN[5:2] == RCS_IDX_PM0) && WB_DAT_IN[RCS_PM0_SOFT_RST];
        wdt_rst = WDT_UNDERFLOW_IN && pm1_r[RCS_PM1_WDT_ACTION];
        osc_rst = osc_stop_r && !ctrl_r[RCS_CTRL_STOP_ACT];
        any_cause = pin_low_r || soft_req_r || wdt_rst || osc_rst;
    end

    // reset combiner: causes merge and release synchronously after a stretch
    always_comb begin
        soft_req_nxt = soft_wr;
        halt_nxt = halt_r;
        stretch_nxt = stretch_r;
        sys_rst_nxt = sys_rst_r;
        if (osc_rst) begin
            halt_nxt = 1'b1;
        end else if (pin_low_r) begin
            halt_nxt = 1'b0;
        end
        if (any_cause) begin
            stretch_nxt = RCS_STRETCH;
            sys_rst_nxt = 1'b1;
        end else if (stretch_r != 4'h0) begin
            stretch_nxt = stretch_r - 4'h1;
        end else begin
            sys_rst_nxt = 1'b0;
        end
    end

    // registers and their forced bits; reset cause flags survive soft resets
    always_comb begin
        pm1_nxt = pm1_r;
        cm0_nxt = cm0_r;
        ctrl_nxt = ctrl_r;
        prot_nxt = prot_r;
        cause_nxt = cause_r;
        if (sys_rst_r) begin
            pm1_nxt = RCS_PM1_RST;
            cm0_nxt = rcs_cm0_t'(RCS_CM0_RST);
            // stop action and on-chip select kept over an oscillator stop reset
            if (pin_low_r) begin
                ctrl_nxt = RCS_CTRL_RST;
                prot_nxt = 1'b0;
            end
        end else if (wb_wr) begin
            unique case (WB_ADR_IN[5:2])
                RCS_IDX_PM1: begin
                    pm1_nxt = (pm1_r & ~RCS_PM1_WMASK) | (WB_DAT_IN[7:0] & RCS_PM1_WMASK);
                    pm1_nxt[RCS_PM1_WDT_ACTION] = pm1_r[RCS_PM1_WDT_ACTION] | WB_DAT_IN[2];
                end
                RCS_IDX_CM0: if (prot_r) cm0_nxt = rcs_cm0_t'(WB_DAT_IN[7:0]);
                RCS_IDX_CTRL: if (prot_r) ctrl_nxt = WB_DAT_IN[7:0];
                RCS_IDX_PROT: prot_nxt = WB_DAT_IN[0];
                RCS_IDX_STAT: cause_nxt = cause_r & ~WB_DAT_IN[3:0];
                default: ;
            endcase
        end
        if (FLASH_REWRITE_IN) begin
            pm1_nxt[RCS_PM1_AREA_EXP] = 1'b1;
        end
        if (!cm0_nxt.sub_pin_en || STOP_ENTRY_IN) begin
            cm0_nxt.sub_drive = 1'b1;
        end
        if (STOP_ENTRY_IN && STOP_FROM_FAST_IN) begin
            cm0_nxt.div8 = 1'b1;
        end
        if (!ctrl_nxt[RCS_CTRL_ONCHIP] && cm0_nxt.main_stop) begin
            cm0_nxt.div8 = 1'b1;
            ctrl_nxt[RCS_CTRL_MAIN_DRV] = 1'b1;
        end
        // sets win over the software clear
        if (pin_low_r) cause_nxt[RCS_CAUSE_PIN] = 1'b1;
        if (soft_req_r) cause_nxt[RCS_CAUSE_SOFT] = 1'b1;
        if (wdt_rst) cause_nxt[RCS_CAUSE_WDT] = 1'b1;
        if (osc_rst) cause_nxt[RCS_CAUSE_OSC] = 1'b1;
    end

    // bus answer: one cycle after the request, unmapped reads return zero
    always_comb begin
        ack_nxt = wb_hit;
        rdat_nxt = rdat_r;
        if (wb_hit) begin
            unique case (WB_ADR_IN[5:2])
                RCS_IDX_PM1: rdat_nxt = {24'h000000, pm1_r};
                RCS_IDX_CM0: rdat_nxt = {24'h000000, cm0_r};
                RCS_IDX_CTRL: rdat_nxt = {24'h000000, ctrl_r};
                RCS_IDX_PROT: rdat_nxt = {31'h00000000, prot_r};
                RCS_IDX_STAT: rdat_nxt = {27'h0000000, halt_r, cause_r};
                default: rdat_nxt = 32'h00000000;
            endcase
        end
    end

    // clock output: fC direct, f8 and f32 from a free divider of the system clock;
    // the pin is registered so the port sees no glitch when the select changes
    always_comb begin
        div_nxt = div_r + 5'h01;
        unique case (cm0_r.clkout_sel)
            2'b00: clkout_nxt = 1'b0;
            2'b01: clkout_nxt = FC_IN;
            2'b10: clkout_nxt = div_r[2];
            2'b11: clkout_nxt = div_r[4];
        endcase
    end

    // memory wait: one stall cycle per internal access when enabled
    always_comb begin
        ram_ok = in_range(MEM_ADDR_IN, RCS_RAM_LO, RCS_RAM_HI);
        rom_ok = MEM_ADDR_IN >= RCS_ROM_LO;
        mem_wait_nxt = MEM_REQ_IN && pm1_r[RCS_PM1_ACC_WAIT] && !mem_wait_r;
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            rstn_sync_r <= 3'h0;
            osc_sync_r <= 3'h0;
            pin_low_r <= 1'b1;
            osc_stop_r <= 1'b0;
            pm1_r <= RCS_PM1_RST;
            cm0_r <= rcs_cm0_t'(RCS_CM0_RST);
            ctrl_r <= RCS_CTRL_RST;
            prot_r <= 1'b0;
            cause_r <= 4'h1;
            soft_req_r <= 1'b0;
            halt_r <= 1'b0;
            stretch_r <= RCS_STRETCH;
            sys_rst_r <= 1'b1;
            ack_r <= 1'b0;
            rdat_r <= 32'h00000000;
            div_r <= 5'h00;
            clkout_r <= 1'b0;
            mem_wait_r <= 1'b0;
        end else begin
            rstn_sync_r <= rstn_sync_nxt;
            osc_sync_r <= osc_sync_nxt;
            pin_low_r <= pin_low_nxt;
            osc_stop_r <= osc_stop_nxt;
            pm1_r <= pm1_nxt;
            cm0_r <= cm0_nxt;
            ctrl_r <= ctrl_nxt;
            prot_r <= prot_nxt;
            cause_r <= cause_nxt;
            soft_req_r <= soft_req_nxt;
            halt_r <= halt_nxt;
            stretch_r <= stretch_nxt;
            sys_rst_r <= sys_rst_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
            div_r <= div_nxt;
            clkout_r <= clkout_nxt;
            mem_wait_r <= mem_wait_nxt;
        end
    end

    // outputs; RAM itself lives outside and is never cleared here
    always_comb begin
        WB_ACK_OUT = ack_r;
        WB_DAT_OUT = rdat_r;
        SYS_RESET_OUT = sys_rst_r;
        PORTS_INPUT_OUT = sys_rst_r;
        OSC_RESET_OUT = pin_low_r;
        CPU_HALT_OUT = halt_r;
        CLKOUT_OUT = clkout_r;
        CLKOUT_OE_OUT = cm0_r.clkout_sel != 2'b00;
        PERIPH_CLK_EN_OUT = !(WAIT_MODE_IN && cm0_r.wait_stop);
        SUB_DIV32_EN_OUT = 1'b1;
        WDT_IRQ_OUT = WDT_UNDERFLOW_IN && !pm1_r[RCS_PM1_WDT_ACTION];
        OSC_IRQ_OUT = osc_stop_r && ctrl_r[RCS_CTRL_STOP_ACT];
        MEM_READY_OUT = MEM_REQ_IN && (!pm1_r[RCS_PM1_ACC_WAIT] || mem_wait_r);
        MEM_ALLOWED_OUT = pm1_r[RCS_PM1_AREA_EXP] || (MEM_IS_ROM_IN ? rom_ok : ram_ok);
        PM1_OUT = pm1_r;
        CM0_OUT = cm0_r;
    end

endmodule : rcs_top

// *** sim/rcs_ext_model.sv ***
// model of the external reset circuit and the main oscillator stop detector
// assumes one clock shared with the block; the bench asks for reset pulses and failures
module rcs_ext_model #(
    parameter int LOW_CYCLES = 20
) (
    input wire logic clk_in,
    input wire logic pulse_in,
    input wire logic osc_fail_in,
    output logic reset_n_out = 1'b0,
    output logic osc_stop_out = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = LOW_CYCLES;
    // pin starts low at power-on; every pulse holds it low a full count of clocks
    always @(posedge clk_in) begin
        cnt <= pulse_in ? LOW_CYCLES : (cnt > 0 ? cnt - 1 : 0);
        reset_n_out <= !pulse_in && cnt <= 1;
        osc_stop_out <= osc_fail_in;
    end
endmodule : rcs_ext_model

// *** sim/rcs_top_chk.sv ***
// checker for bus, reset and clock control behaviour at the top ports
// assumes rcs_pkg is compiled first; attached to rcs_top by the bind below
module rcs_top_chk
    import rcs_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [31:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    input wire logic WB_ACK_OUT,
    input wire logic RESET_N_IN,
    input wire logic WDT_UNDERFLOW_IN,
    input wire logic WAIT_MODE_IN,
    input wire logic MEM_REQ_IN,
    input wire logic MEM_READY_OUT,
    input wire logic SYS_RESET_OUT,
    input wire logic PORTS_INPUT_OUT,
    input wire logic OSC_RESET_OUT,
    input wire logic CLKOUT_OE_OUT,
    input wire logic PERIPH_CLK_EN_OUT,
    input wire logic SUB_DIV32_EN_OUT,
    input wire logic [7:0] PM1_OUT,
    input wire logic [7:0] CM0_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);
    // a new request, and a soft reset request among them
    sequence s_req; WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT; endsequence
    sequence s_soft; WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && WB_WE_IN && WB_SEL_IN[0] &&
        WB_ADR_IN[5:2] == RCS_IDX_PM0 && WB_DAT_IN[RCS_PM0_SOFT_RST] && !SYS_RESET_OUT; endsequence
    property p_ack; s_req |=> WB_ACK_OUT ##1 !WB_ACK_OUT; endproperty
    a_ack: assert property (p_ack) else $error("ack not a single pulse");
    property p_soft; s_soft |-> ##[1:3] SYS_RESET_OUT; endproperty
    a_soft: assert property (p_soft) else $error("soft reset missing");
    property p_wdt;
        WDT_UNDERFLOW_IN && PM1_OUT[RCS_PM1_WDT_ACTION] && !SYS_RESET_OUT |-> ##[1:4] SYS_RESET_OUT;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog reset missing");
    property p_sticky; PM1_OUT[RCS_PM1_WDT_ACTION] && !SYS_RESET_OUT |=> PM1_OUT[2] || SYS_RESET_OUT; endproperty
    a_sticky: assert property (p_sticky) else $error("watchdog action cleared");
    // wait state: not ready in the first cycle of the request, ready in the second
    property p_wait; $rose(MEM_REQ_IN) && PM1_OUT[RCS_PM1_ACC_WAIT] |-> !MEM_READY_OUT ##1 MEM_READY_OUT; endproperty
    a_wait: assert property (p_wait) else $error("wait state wrong");
    property p_pins; !RESET_N_IN [*6] |-> SYS_RESET_OUT && PORTS_INPUT_OUT && OSC_RESET_OUT; endproperty
    a_pins: assert property (p_pins) else $error("pin reset not applied");
    property p_clkout; CM0_OUT[1:0] == 2'h0 && $stable(CM0_OUT) |-> !CLKOUT_OE_OUT; endproperty
    a_clkout: assert property (p_clkout) else $error("clock pin driven as port");
    property p_subdrv; !CM0_OUT[RCS_CM0_SUB_PIN_EN] |-> CM0_OUT[RCS_CM0_SUB_DRIVE]; endproperty
    a_subdrv: assert property (p_subdrv) else $error("sub drive not forced");
    property p_periph;
        WAIT_MODE_IN && CM0_OUT[RCS_CM0_WAIT_STOP] |-> !PERIPH_CLK_EN_OUT && SUB_DIV32_EN_OUT;
    endproperty
    a_periph: assert property (p_periph) else $error("wait gating wrong");
endmodule : rcs_top_chk

bind rcs_top rcs_top_chk u_chk (.*);

// *** sim/test_reset_and_clock_select.sv ***
// bench for the reset and clock select block: wishbone task and one task per scenario
// assumes rcs_pkg, rcs_top, rcs_ext_model and the bound checker are compiled first
module test_reset_and_clock_select import rcs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    rcs_wb_req_t req = '0;
    logic wdt = 1'b0;
    logic wait_m = 1'b0;
    logic mreq = 1'b0;
    logic stop_e = 1'b0;
    logic pulse = 1'b0;
    logic ofail = 1'b0;
    logic fc = 1'b0;
    logic flash = 1'b0;
    logic fast = 1'b0;
    logic mrom = 1'b0;
    logic [19:0] maddr = 20'h00400;
    logic [31:0] rd;
    logic ack, sys, pin_in, osc_rst, halt, clko_oe, pen, s32, ready, rst_n, osc_stop;
    logic clko, wirq, oirq, allowed;
    int n_errors = 0;
    int checks_done = 0;
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin n_errors++; $display("FAIL %s exp %h got %h", n, e, a); end end

    // 100 MHz clock and a sub clock level toggling on every rising edge, at half its rate
    always #5 clk = ~clk;
    always @(posedge clk) fc <= ~fc;

    rcs_top u_dut (
        .CLK_IN(clk), .SRST_IN(srst), .WB_CYC_IN(req.cyc), .WB_STB_IN(req.stb), .WB_WE_IN(req.we),
        .WB_ADR_IN({26'h0, req.idx, 2'h0}), .WB_SEL_IN(req.sel), .WB_DAT_IN(req.dat), .WB_DAT_OUT(rd),
        .WB_ACK_OUT(ack), .RESET_N_IN(rst_n), .OSC_STOP_IN(osc_stop), .WDT_UNDERFLOW_IN(wdt),
        .FLASH_REWRITE_IN(flash), .STOP_ENTRY_IN(stop_e), .STOP_FROM_FAST_IN(fast), .WAIT_MODE_IN(wait_m),
        .FC_IN(fc), .MEM_REQ_IN(mreq), .MEM_ADDR_IN(maddr), .MEM_IS_ROM_IN(mrom), .MEM_READY_OUT(ready),
        .MEM_ALLOWED_OUT(allowed), .SYS_RESET_OUT(sys), .PORTS_INPUT_OUT(pin_in), .OSC_RESET_OUT(osc_rst),
        .CPU_HALT_OUT(halt), .CLKOUT_OUT(clko), .CLKOUT_OE_OUT(clko_oe), .PERIPH_CLK_EN_OUT(pen),
        .SUB_DIV32_EN_OUT(s32), .WDT_IRQ_OUT(wirq), .OSC_IRQ_OUT(oirq), .PM1_OUT(), .CM0_OUT()
    );
    rcs_ext_model u_ext (.clk_in(clk), .pulse_in(pulse), .osc_fail_in(ofail),
        .reset_n_out(rst_n), .osc_stop_out(osc_stop));

    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test

    // one classic cycle; held until ack is sampled, read data compared when reading
    task automatic acc(input logic we, input logic [3:0] idx, input logic [7:0] d, input logic [7:0] e);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b1, we, 4'hF, idx, {24'h0, d}};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        req <= '0;
        if (n >= 50) begin
            n_errors++;
            stop_test();
        end
        if (!we) `CHK($sformatf("reg %h", idx), e, rd[7:0])
    endtask : acc

    // bounded wait for the combined reset to reach a level
    task automatic wsys(input logic v);
        int n;
        n = 0;
        while (sys !== v && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) begin
            n_errors++;
            stop_test();
        end
    endtask : wsys

    task automatic t_clock;
        acc(0, RCS_IDX_PM1, 0, 8'h08);
        acc(1, RCS_IDX_CM0, 8'h01, 0);
        acc(0, RCS_IDX_CM0, 0, 8'h48);
        acc(1, RCS_IDX_PROT, 8'h01, 0);
        for (int s = 0; s < 4; s++) begin
            acc(1, RCS_IDX_CM0, 8'(s), 0);
            acc(0, RCS_IDX_CM0, 0, 8'(s) | 8'h08);
            `CHK("clkout oe", s != 0, clko_oe)
            if (s == 1) `CHK("clkout fc", ~fc, clko)
        end
        acc(1, RCS_IDX_CM0, 8'h10, 0);
        acc(1, RCS_IDX_CM0, 8'h90, 0);
        acc(1, RCS_IDX_CM0, 8'hB0, 0);
        acc(0, RCS_IDX_CM0, 0, 8'hF0);
        acc(1, RCS_IDX_CTRL, 8'h00, 0);
        acc(0, RCS_IDX_CTRL, 0, 8'h04);
        acc(0, 4'hF, 0, 8'h00);
    endtask : t_clock

    task automatic t_stop;
        acc(1, RCS_IDX_CM0, 8'h10, 0);
        // stop entry from a slow mode first, then from a fast one
        for (int f = 0; f < 2; f++) begin
            @(posedge clk);
            fast <= f[0];
            stop_e <= 1'b1;
            @(posedge clk);
            stop_e <= 1'b0;
            acc(0, RCS_IDX_CM0, 0, f[0] ? 8'h58 : 8'h18);
        end
    endtask : t_stop

    task automatic t_wait;
        acc(1, RCS_IDX_PM1, 8'h80, 0);
        acc(1, RCS_IDX_CM0, 8'h04, 0);
        mreq <= 1'b1;
        wait_m <= 1'b1;
        #1 `CHK("ready first", 1'b0, ready)
        @(posedge clk);
        #1 `CHK("ready second", 1'b1, ready)
        `CHK("periph en", 1'b0, pen)
        `CHK("div32 en", 1'b1, s32)
        @(posedge clk);
        mreq <= 1'b0;
        wait_m <= 1'b0;
    endtask : t_wait

    task automatic t_wdt;
        acc(1, RCS_IDX_PM1, 8'h04, 0);
        acc(1, RCS_IDX_PM1, 8'h00, 0);
        acc(0, RCS_IDX_PM1, 0, 8'h04);
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
        wsys(1'b1);
        wsys(1'b0);
        acc(0, RCS_IDX_PM1, 0, 8'h08);
        // with the action bit clear an underflow only raises the interrupt
        wdt <= 1'b1;
        #1 `CHK("wdt irq", 1'b1, wirq)
        @(posedge clk);
        wdt <= 1'b0;
        #1 `CHK("no wdt reset", 1'b0, sys)
    endtask : t_wdt

    task automatic t_soft;
        acc(1, RCS_IDX_CM0, 8'h01, 0);
        acc(1, RCS_IDX_PM0, 8'h08, 0);
        wsys(1'b1);
        wsys(1'b0);
        acc(0, RCS_IDX_CM0, 0, 8'h48);
        acc(0, RCS_IDX_PROT, 0, 8'h01);
    endtask : t_soft

    // area limits with expansion cleared, then forced open by flash rewrite
    task automatic t_area;
        acc(1, RCS_IDX_PM1, 8'h00, 0);
        maddr <= RCS_RAM_HI;
        #1 `CHK("ram top", 1'b1, allowed)
        @(posedge clk);
        maddr <= RCS_RAM_HI + 20'h00001;
        #1 `CHK("ram above", 1'b0, allowed)
        @(posedge clk);
        mrom <= 1'b1;
        maddr <= RCS_ROM_LO - 20'h00001;
        #1 `CHK("rom below", 1'b0, allowed)
        @(posedge clk);
        maddr <= RCS_ROM_LO;
        #1 `CHK("rom base", 1'b1, allowed)
        @(posedge clk);
        maddr <= RCS_RAM_LO - 20'h00001;
        mrom <= 1'b0;
        flash <= 1'b1;
        #1 `CHK("ram below", 1'b0, allowed)
        repeat (2) @(posedge clk);
        `CHK("area forced", 1'b1, allowed)
        flash <= 1'b0;
    endtask : t_area

    task automatic t_pin;
        // stop detected with interrupt action: no reset, interrupt raised
        acc(1, RCS_IDX_CTRL, 8'h02, 0);
        ofail <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK("osc irq", 1'b1, oirq)
        `CHK("no osc reset", 1'b0, sys)
        acc(1, RCS_IDX_CTRL, 8'h00, 0);
        wsys(1'b1);
        repeat (8) @(posedge clk);
        `CHK("halt set", 1'b1, halt)
        ofail <= 1'b0;
        pulse <= 1'b1;
        @(posedge clk);
        pulse <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK("ports input", 1'b1, pin_in)
        `CHK("osc reset", 1'b1, osc_rst)
        wsys(1'b0);
        `CHK("halt clear", 1'b0, halt)
        acc(0, RCS_IDX_PROT, 0, 8'h00);
    endtask : t_pin

    // main sequence: reset, then the scenarios in turn
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        wsys(1'b0);
        t_clock();
        t_stop();
        t_wait();
        t_wdt();
        t_soft();
        t_area();
        t_pin();
        stop_test();
    end
endmodule : test_reset_and_clock_select
